// >>> logic/efr_pkg.sv
// Purpose: Constants for the encoder receiver fault readback word and its serial port
// Assumes: Serial pins already synchronous to CORE_CLK
// Notes:   Field positions, command codes and reset values
// Function
// R1: Bit 14 flags first receiver true line fault, bit 15 its complement.
// R2: Bit 13 flags a differential fault on the first receiver.
// R3: Bit 11 flags second receiver true line fault, bit 12 its complement.
// R4: Bit 10 flags a differential fault on the second receiver.
// R5: Bit 8 flags index receiver true line fault, bit 9 its complement.
// R6: Bit 7 flags a differential fault on the index receiver.
// R7: Bit 5 flags fourth receiver true input fault, bit 6 its complement.
// R8: Bit 4 flags a differential fault on the fourth receiver.
// R9: Bit 3 flags a low-voltage fault on auxiliary input one.
// R10: Bit 2 flags auxiliary input one high-voltage fault, only in TTL mode.
// R11: Bit 1 flags a low-voltage fault on auxiliary input two.
// R12: Bit 0 flags auxiliary input two high-voltage fault, only in TTL mode.
// R13: Fault word returned after change-config or any unassigned command code; code returns CONFIG_WORD after CMD_CONFIG.
// R14: Serial output changes on falling clock edge; input sampled on rising.
// R15: Host gives at least sixteen clocks per frame; fewer discards input.
// R16: Fault interrupt stays latched until fault status is read serially.
// R17: Word shifts out most significant bit first, bit 15 leading.
package efr_pkg;

    // ------------------------------------------------------------
    // Word geometry
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS  = 5;
    localparam logic [4:0] MIN_PULSES = 5'h10;

    // ------------------------------------------------------------
    // Fault word field positions
    // ------------------------------------------------------------
    localparam int FIRST_COMP_POS  = 15;
    localparam int FIRST_TRUE_POS  = 14;
    localparam int FIRST_DIFF_POS  = 13;
    localparam int SECOND_COMP_POS = 12;
    localparam int SECOND_TRUE_POS = 11;
    localparam int SECOND_DIFF_POS = 10;
    localparam int INDEX_COMP_POS  = 9;
    localparam int INDEX_TRUE_POS  = 8;
    localparam int INDEX_DIFF_POS  = 7;
    localparam int FOURTH_COMP_POS = 6;
    localparam int FOURTH_TRUE_POS = 5;
    localparam int FOURTH_DIFF_POS = 4;
    localparam int AUX1_LOW_POS    = 3;
    localparam int AUX1_HIGH_POS   = 2;
    localparam int AUX2_LOW_POS    = 1;
    localparam int AUX2_HIGH_POS   = 0;

    // ------------------------------------------------------------
    // Command field and codes
    // ------------------------------------------------------------
    localparam int CMD_HI = 15;
    localparam int CMD_LO = 13;
    localparam logic [2:0] CMD_STATUS = 3'h2;
    localparam logic [2:0] CMD_CONFIG = 3'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [4:0]  CNT_RST   = 5'h00;
    localparam logic        IRQ_N_RST = 1'h1;
    localparam logic [2:0]  CMD_RST   = 3'h0;
    localparam logic        FLAG_RST  = 1'h0;
    localparam logic        CS_N_RST  = 1'h1;

    typedef enum logic [1:0] {
        RESP_ZERO   = 2'b00,
        RESP_DETAIL = 2'b01,
        RESP_STATUS = 2'b10,
        RESP_CONFIG = 2'b11
    } efr_resp_type;

endpackage

// >>> logic/efr_spi_if.sv
// Purpose: Carrier between the serial shifter and the fault core
// Assumes: One clock domain
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/1ps
interface efr_spi_if;
    logic [15:0] load_word;
    logic [15:0] rx_word;
    logic        frame_start;
    logic        frame_end;
    logic        frame_full;

    modport shifter (
        input  load_word,
        output rx_word,
        output frame_start,
        output frame_end,
        output frame_full
    );

    modport core (
        output load_word,
        input  rx_word,
        input  frame_start,
        input  frame_end,
        input  frame_full
    );
endinterface

// >>> logic/efr_spi_shift.sv
// Purpose: Serial frame shifter, one register loops out and in
// Assumes: Clock and select pins sampled on CORE_CLK, slower than it
// Notes:   More than sixteen clocks pass input to output for chaining
`timescale 1ns/1ps
module efr_spi_shift (
    // Clock and reset
    input  wire logic    core_clk,
    input  wire logic    resetn,
    // Serial pins
    input  wire logic    sclk,
    input  wire logic    cs_n,
    input  wire logic    sdi,
    output logic         sdo,
    output logic         sdo_oe,
    // Core side
    efr_spi_if.shifter   bus
);

    typedef struct packed {
        logic        sclk_q;
        logic        cs_n_q;
        logic [15:0] sh_q;
        logic [4:0]  cnt_q;
        logic        sdo_q;
        logic        oe_q;
    } efr_shift_type;

    efr_shift_type st_q;
    efr_shift_type st_d;

    logic rise;
    logic fall;

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    assign rise            = sclk & ~st_q.sclk_q & ~cs_n;
    assign fall            = ~sclk & st_q.sclk_q & ~cs_n;
    assign bus.frame_start = st_q.cs_n_q & ~cs_n;
    assign bus.frame_end   = ~st_q.cs_n_q & cs_n;
    assign bus.frame_full  = (st_q.cnt_q >= efr_pkg::MIN_PULSES); // R15
    assign bus.rx_word     = st_q.sh_q;
    assign sdo             = st_q.sdo_q;
    assign sdo_oe          = st_q.oe_q;

    always_comb begin
        st_d        = st_q;
        st_d.sclk_q = sclk;
        st_d.cs_n_q = cs_n;
        if (bus.frame_start) begin
            st_d.sh_q  = bus.load_word;
            st_d.sdo_q = bus.load_word[efr_pkg::WORD_BITS-1]; // R17
            st_d.cnt_q = efr_pkg::CNT_RST;
            st_d.oe_q  = 1'h1;
        end else if (bus.frame_end) begin
            st_d.oe_q = 1'h0;
        end else if (rise) begin
            st_d.sh_q = {st_q.sh_q[14:0], sdi}; // R14
            if (!bus.frame_full) begin
                st_d.cnt_q = st_q.cnt_q + 5'h01;
            end
        end else if (fall) begin
            st_d.sdo_q = st_q.sh_q[efr_pkg::WORD_BITS-1]; // R14 R17
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q.sclk_q <= efr_pkg::FLAG_RST;
            st_q.cs_n_q <= efr_pkg::CS_N_RST;
            st_q.sh_q   <= efr_pkg::WORD_RST;
            st_q.cnt_q  <= efr_pkg::CNT_RST;
            st_q.sdo_q  <= efr_pkg::FLAG_RST;
            st_q.oe_q   <= efr_pkg::FLAG_RST;
        end else begin
            st_q <= st_d;
        end
    end

endmodule // efr_spi_shift

// >>> logic/efr_fault_readback.sv
// Purpose: Detailed fault status word, its serial readback and the fault interrupt
// Assumes: Fault levels come from the receiver front ends, synchronous to CORE_CLK
// Notes:   Word is frozen at chip select fall; other readback words come in as ports
`timescale 1ns/1ps
module efr_fault_readback (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    // Serial port
    input  wire logic        SPI_SCLK,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_SDI,
    output logic             FAULT_IRQ_SERIAL_OUT_PIN,
    output logic             FAULT_IRQ_SERIAL_OUT_PIN_OE,
    // Receiver line faults, bit 1 complement, bit 0 true
    input  wire logic [1:0]  FIRST_RX_LINE_FAULT,
    input  wire logic [1:0]  SECOND_RX_LINE_FAULT,
    input  wire logic [1:0]  INDEX_RX_LINE_FAULT,
    input  wire logic        FOURTH_RX_COMP_LINE_FAULT,
    input  wire logic        FOURTH_RX_TRUE_LINE_FAULT,
    // Receiver differential faults
    input  wire logic        FIRST_RX_DIFF_FAULT,
    input  wire logic        SECOND_RX_DIFF_FAULT,
    input  wire logic        INDEX_RX_DIFF_FAULT,
    input  wire logic        FOURTH_RX_DIFF_FAULT,
    // Auxiliary input faults and modes
    input  wire logic        AUX_IN_ONE_LOW_FAULT,
    input  wire logic        AUX_IN_ONE_HIGH_FAULT,
    input  wire logic        AUX_IN_TWO_LOW_FAULT,
    input  wire logic        AUX_IN_TWO_HIGH_FAULT,
    input  wire logic        AUX_ONE_TTL_MODE,
    input  wire logic        AUX_TWO_TTL_MODE,
    // Other readback words
    input  wire logic [15:0] STATUS_WORD,
    input  wire logic [15:0] CONFIG_WORD,
    // Interrupt and command view
    output logic             FAULT_IRQ_N,
    output logic [2:0]       LAST_COMMAND,
    output logic             LAST_COMMAND_VALID
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        efr_pkg::efr_resp_type resp_q;
        logic                  irq_n_q;
        logic [15:0]           prev_q;
        logic [2:0]            cmd_q;
        logic                  cmd_vld_q;
        logic                  late_q;
    } efr_core_type;

    efr_core_type st_q;
    efr_core_type st_d;

    efr_spi_if    spi ();

    logic [15:0]  raw_word;
    logic [15:0]  allow;
    logic [15:0]  fault_word;
    logic [15:0]  new_fault;
    logic [2:0]   rx_cmd;
    logic         read_done;

    logic         frame_taken;
    logic         irq_set;
    logic         irq_clear;
    logic         late_set;
    efr_pkg::efr_resp_type next_resp;

    // ------------------------------------------------------------
    // Raw fault word assembly
    // ------------------------------------------------------------
    always_comb begin
        raw_word = efr_pkg::WORD_RST;
        // First receiver
        raw_word[efr_pkg::FIRST_COMP_POS]  = FIRST_RX_LINE_FAULT[1];   // R1
        raw_word[efr_pkg::FIRST_TRUE_POS]  = FIRST_RX_LINE_FAULT[0];   // R1
        raw_word[efr_pkg::FIRST_DIFF_POS]  = FIRST_RX_DIFF_FAULT;      // R2

        // Second receiver
        raw_word[efr_pkg::SECOND_COMP_POS] = SECOND_RX_LINE_FAULT[1];  // R3
        raw_word[efr_pkg::SECOND_TRUE_POS] = SECOND_RX_LINE_FAULT[0];  // R3
        raw_word[efr_pkg::SECOND_DIFF_POS] = SECOND_RX_DIFF_FAULT;     // R4

        // Index receiver
        raw_word[efr_pkg::INDEX_COMP_POS]  = INDEX_RX_LINE_FAULT[1];   // R5
        raw_word[efr_pkg::INDEX_TRUE_POS]  = INDEX_RX_LINE_FAULT[0];   // R5
        raw_word[efr_pkg::INDEX_DIFF_POS]  = INDEX_RX_DIFF_FAULT;      // R6

        // Fourth receiver
        raw_word[efr_pkg::FOURTH_COMP_POS] = FOURTH_RX_COMP_LINE_FAULT; // R7
        raw_word[efr_pkg::FOURTH_TRUE_POS] = FOURTH_RX_TRUE_LINE_FAULT; // R7
        raw_word[efr_pkg::FOURTH_DIFF_POS] = FOURTH_RX_DIFF_FAULT;     // R8

        // Auxiliary input one
        raw_word[efr_pkg::AUX1_LOW_POS]    = AUX_IN_ONE_LOW_FAULT;     // R9
        raw_word[efr_pkg::AUX1_HIGH_POS]   = AUX_IN_ONE_HIGH_FAULT;    // R10

        // Auxiliary input two
        raw_word[efr_pkg::AUX2_LOW_POS]    = AUX_IN_TWO_LOW_FAULT;     // R11
        raw_word[efr_pkg::AUX2_HIGH_POS]   = AUX_IN_TWO_HIGH_FAULT;    // R12
    end

    // ------------------------------------------------------------
    // Mode gating of high-voltage bits
    // ------------------------------------------------------------
    // High faults mean nothing outside TTL mode, so they are forced to zero
    always_comb begin
        allow = 16'hFFFF;
        allow[efr_pkg::AUX1_HIGH_POS] = AUX_ONE_TTL_MODE; // R10
        allow[efr_pkg::AUX2_HIGH_POS] = AUX_TWO_TTL_MODE; // R12
    end

    genvar gi;
    generate
        for (gi = 0; gi < efr_pkg::WORD_BITS; gi++) begin : g_bit
            assign fault_word[gi] = raw_word[gi] & allow[gi];
            assign new_fault[gi]  = fault_word[gi] & ~st_q.prev_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    efr_spi_shift u_shift (
        .core_clk (CORE_CLK),
        .resetn   (RESETN),
        .sclk     (SPI_SCLK),
        .cs_n     (SPI_CS_N),
        .sdi      (SPI_SDI),
        .sdo      (FAULT_IRQ_SERIAL_OUT_PIN),
        .sdo_oe   (FAULT_IRQ_SERIAL_OUT_PIN_OE),
        .bus      (spi.shifter)
    );

    // ------------------------------------------------------------
    // Readback selection
    // ------------------------------------------------------------
    // Word is chosen by the previous command; none yet gives zeros
    always_comb begin
        unique case (st_q.resp_q)
            efr_pkg::RESP_ZERO:   spi.load_word = efr_pkg::WORD_RST;
            efr_pkg::RESP_DETAIL: spi.load_word = fault_word; // R13
            efr_pkg::RESP_STATUS: spi.load_word = STATUS_WORD;
            efr_pkg::RESP_CONFIG: spi.load_word = CONFIG_WORD;
        endcase
    end

    assign rx_cmd      = spi.rx_word[efr_pkg::CMD_HI:efr_pkg::CMD_LO];
    assign frame_taken = spi.frame_end & spi.frame_full; // R15
    assign read_done   = frame_taken & (st_q.resp_q == efr_pkg::RESP_DETAIL);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Every code without a readback of its own asks for the detailed word
    always_comb begin
        next_resp = efr_pkg::RESP_DETAIL; // R13
        if (rx_cmd == efr_pkg::CMD_STATUS) begin
            next_resp = efr_pkg::RESP_STATUS;
        end else if (rx_cmd == efr_pkg::CMD_CONFIG) begin
            next_resp = efr_pkg::RESP_CONFIG;
        end
    end

    // ------------------------------------------------------------
    // Interrupt latch
    // ------------------------------------------------------------
    // A fault rising after the word froze was never shown to the host
    // One more flag, so a read never clears a fault it did not carry
    assign irq_set   = |new_fault;
    assign late_set  = irq_set & FAULT_IRQ_SERIAL_OUT_PIN_OE;
    assign irq_clear = read_done & ~st_q.late_q;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        st_d.prev_q = fault_word;
        // Short frames leave the pending readback untouched
        if (frame_taken) begin // R15
            st_d.cmd_q     = rx_cmd;
            st_d.cmd_vld_q = 1'h1;
            st_d.resp_q    = next_resp; // R13
        end
        // The frozen word already holds a fault rising at chip select fall
        if (spi.frame_start) begin
            st_d.late_q = 1'h0;
        end else if (late_set) begin
            st_d.late_q = 1'h1; // R16
        end
        // A fault arriving with the read keeps the line asserted
        if (irq_set) begin
            st_d.irq_n_q = 1'h0; // R16
        end else if (irq_clear) begin
            st_d.irq_n_q = 1'h1; // R16
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q.resp_q    <= efr_pkg::RESP_ZERO;
            st_q.irq_n_q   <= efr_pkg::IRQ_N_RST;
            st_q.prev_q    <= efr_pkg::WORD_RST;
            st_q.cmd_q     <= efr_pkg::CMD_RST;
            st_q.cmd_vld_q <= efr_pkg::FLAG_RST;
            st_q.late_q    <= efr_pkg::FLAG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign FAULT_IRQ_N        = st_q.irq_n_q;
    assign LAST_COMMAND       = st_q.cmd_q;
    assign LAST_COMMAND_VALID = st_q.cmd_vld_q;

endmodule // efr_fault_readback

// >>> sim/efr_sva.sv
// Purpose: Port checks of the fault readback block
// Assumes: Serial pins sampled on CORE_CLK
// Notes:   Rise counter mirrors the frame length
`timescale 1ns/1ps
module efr_sva (
    // Clock and reset
    input wire logic       CORE_CLK,
    input wire logic       RESETN,
    // Serial port
    input wire logic       SPI_SCLK,
    input wire logic       SPI_CS_N,
    input wire logic       FAULT_IRQ_SERIAL_OUT_PIN,
    input wire logic       FAULT_IRQ_SERIAL_OUT_PIN_OE,
    // Faults and status
    input wire logic [1:0] FIRST_RX_LINE_FAULT,
    input wire logic       FIRST_RX_DIFF_FAULT,
    input wire logic       FAULT_IRQ_N,
    input wire logic [2:0] LAST_COMMAND,
    input wire logic       LAST_COMMAND_VALID
);
    logic       sclk_q;
    logic [4:0] cnt_q;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    // ----------------------------------------
    // Rise counter, saturating so long frames never wrap
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sclk_q <= 1'b0;
            cnt_q  <= 5'h00;
        end else begin
            sclk_q <= SPI_SCLK;
            if (SPI_CS_N) begin
                cnt_q <= 5'h00;
            end else if (SPI_SCLK && !sclk_q && cnt_q != 5'h1F) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_oe_start: assert property ($fell(SPI_CS_N) |=> FAULT_IRQ_SERIAL_OUT_PIN_OE)
        else $error("output enable late at frame start");
    chk_oe_idle: assert property (SPI_CS_N [*2] |-> !FAULT_IRQ_SERIAL_OUT_PIN_OE)
        else $error("output enable high outside frame");
    chk_sdo_fall: assert property ($changed(FAULT_IRQ_SERIAL_OUT_PIN) &&
        FAULT_IRQ_SERIAL_OUT_PIN_OE && $past(FAULT_IRQ_SERIAL_OUT_PIN_OE)
        |-> $past(SPI_SCLK, 2) && !$past(SPI_SCLK)) else $error("data changed off a fall");
    chk_irq_set: assert property ($rose(|{FIRST_RX_LINE_FAULT, FIRST_RX_DIFF_FAULT})
        |=> !FAULT_IRQ_N) else $error("interrupt not raised");
    chk_irq_clear: assert property ($rose(FAULT_IRQ_N)
        |-> $past(SPI_CS_N) && !$past(SPI_CS_N, 2)) else $error("interrupt cleared mid frame");
    chk_cmd_frame: assert property ($changed(LAST_COMMAND)
        |-> $past(SPI_CS_N) && !$past(SPI_CS_N, 2)) else $error("command taken mid frame");
    chk_short_drop: assert property ($rose(SPI_CS_N) && cnt_q < 5'h10
        |=> $stable(LAST_COMMAND) && $stable(LAST_COMMAND_VALID) && !$rose(FAULT_IRQ_N))
        else $error("short frame was used");
    chk_full_take: assert property ($rose(SPI_CS_N) && cnt_q >= 5'h10
        |=> LAST_COMMAND_VALID) else $error("full frame not taken");
    chk_valid_hold: assert property (LAST_COMMAND_VALID |=> LAST_COMMAND_VALID)
        else $error("command valid dropped");
    cov_full: cover property ($rose(SPI_CS_N) && cnt_q == 5'h10);
    cov_short: cover property ($rose(SPI_CS_N) && cnt_q == 5'h08);
    cov_clear: cover property ($rose(FAULT_IRQ_N));
    cov_long: cover property ($rose(SPI_CS_N) && cnt_q == 5'h18);
endmodule // efr_sva

bind efr_fault_readback efr_sva i_sva (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N),
    .FAULT_IRQ_SERIAL_OUT_PIN(FAULT_IRQ_SERIAL_OUT_PIN),
    .FAULT_IRQ_SERIAL_OUT_PIN_OE(FAULT_IRQ_SERIAL_OUT_PIN_OE),
    .FIRST_RX_LINE_FAULT(FIRST_RX_LINE_FAULT), .FIRST_RX_DIFF_FAULT(FIRST_RX_DIFF_FAULT),
    .FAULT_IRQ_N(FAULT_IRQ_N), .LAST_COMMAND(LAST_COMMAND),
    .LAST_COMMAND_VALID(LAST_COMMAND_VALID)
);

// >>> sim/efr_host.sv
// Purpose: Serial host model that reads the fault word
// Assumes: Pins change at falling CORE_CLK
// Notes:   Phases of four cycles, above the two-cycle minimum
`timescale 1ns/1ps
module efr_host (
    // Clock and pins
    input  wire logic core_clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // ----------------------------------------
    // Frame transfer
    // ----------------------------------------
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic xfer(input int np, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        wt(4);
        for (int i = 0; i < np; i++) begin
            sdi = tx[15 - (i % 16)];
            wt(4);
            rx = {rx[14:0], sdo};
            sclk = 1'b1;
            wt(4);
            sclk = 1'b0;
        end
        wt(4);
        cs_n = 1'b1;
        sdi = ~sdi; // Released line must not keep its last value
        wt(4);
    endtask
endmodule // efr_host

// >>> sim/efr_fault_readback_bench.sv
// Purpose: Self-checking bench of the fault readback word
// Assumes: Host model owns the serial pins
// Notes:   Other readback words tied to fixed patterns
`timescale 1ns/1ps
module efr_fault_readback_bench;
    logic        clk, rstn, sclk, cs_n, sdi, sdo, oe, irq_n, vld, sdo_pin;
    logic [15:0] flt, rx;
    logic [2:0]  lcmd;
    logic [1:0]  ttl;
    int          n_mismatch, compares;
    localparam logic [15:0] STAT = 16'h5A3C;
    localparam logic [15:0] CONF = 16'hC3A5;
    logic [2:0]  dc [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    efr_fault_readback i_dut (
        .CORE_CLK(clk), .RESETN(rstn), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
        .FAULT_IRQ_SERIAL_OUT_PIN(sdo), .FAULT_IRQ_SERIAL_OUT_PIN_OE(oe),
        .FIRST_RX_LINE_FAULT(flt[15:14]), .SECOND_RX_LINE_FAULT(flt[12:11]),
        .INDEX_RX_LINE_FAULT(flt[9:8]), .FOURTH_RX_COMP_LINE_FAULT(flt[6]),
        .FOURTH_RX_TRUE_LINE_FAULT(flt[5]), .FIRST_RX_DIFF_FAULT(flt[13]),
        .SECOND_RX_DIFF_FAULT(flt[10]), .INDEX_RX_DIFF_FAULT(flt[7]),
        .FOURTH_RX_DIFF_FAULT(flt[4]), .AUX_IN_ONE_LOW_FAULT(flt[3]),
        .AUX_IN_ONE_HIGH_FAULT(flt[2]), .AUX_IN_TWO_LOW_FAULT(flt[1]),
        .AUX_IN_TWO_HIGH_FAULT(flt[0]), .AUX_ONE_TTL_MODE(ttl[0]), .AUX_TWO_TTL_MODE(ttl[1]),
        .STATUS_WORD(STAT), .CONFIG_WORD(CONF), .FAULT_IRQ_N(irq_n),
        .LAST_COMMAND(lcmd), .LAST_COMMAND_VALID(vld)
    );
    // Released pin shows the inverse, so a late sample cannot pass
    assign sdo_pin = oe ? sdo : ~sdo;
    efr_host i_host (.core_clk(clk), .sdo(sdo_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [15:0] det();
        return flt & {13'h1FFF, ttl[0], 1'b1, ttl[1]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rd(input logic [2:0] cmd, input logic [15:0] exp);
        i_host.xfer(16, {cmd, 13'h0A5}, rx);
        chk(rx, exp);
        chk({13'h0, lcmd}, {13'h0, cmd});
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        flt = 16'h0000;
        ttl = 2'b11;
        n_mismatch = 0;
        compares = 0;
        repeat (12) @(negedge clk);
        chk({13'h0, irq_n, vld, oe}, 16'h0004);
        rstn = 1'b1;
        i_host.wt(2);
        rd(3'h5, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            flt = 16'h0001 << i;
            i_host.wt(3);
            chk({15'h0, irq_n}, 16'h0000);
            rd(dc[i % 6], det());
            chk({15'h0, irq_n}, 16'h0001);
        end
        rd(3'h2, 16'h8000);
        rd(3'h7, STAT);
        rd(3'h0, CONF);
        ttl = 2'b00;
        flt = 16'h0005;
        i_host.wt(3);
        rd(3'h0, 16'h0000);
        ttl = 2'b11;
        i_host.wt(3);
        rd(3'h0, 16'h0005);
        flt = 16'h0010;
        i_host.wt(3);
        i_host.xfer(8, {3'h2, 13'h0}, rx);
        chk({15'h0, irq_n}, 16'h0000);
        chk({13'h0, lcmd}, 16'h0000);
        rd(3'h0, 16'h0010);
        chk({15'h0, irq_n}, 16'h0001);
        i_host.xfer(24, {3'h2, 13'h0A5}, rx);
        chk(rx, 16'h1040);
        chk({13'h0, lcmd}, 16'h0005);
        rd(3'h5, 16'h0010);
        rstn = 1'b0;
        i_host.wt(3);
        chk({10'h0, lcmd, irq_n, vld, oe}, 16'h0004);
        rstn = 1'b1;
        i_host.wt(2);
        rd(3'h5, 16'h0000);
        chk({15'h0, irq_n}, 16'h0000);
        rd(3'h0, 16'h0010);
        chk({15'h0, irq_n}, 16'h0001);
        end_sim();
    end
endmodule // efr_fault_readback_bench
